// [inc/rfs_pkg.sv]
package rfs_pkg;

    // clock
    localparam int CLK_PERIOD_NS = 50;

    // detector filters, in their own units and in cycles
    localparam int OV_FILTER_NS = 1000;
    localparam int OV_FILTER_CYCLES = OV_FILTER_NS / CLK_PERIOD_NS;
    localparam int UV_FILTER_NS = 5000;
    localparam int UV_FILTER_CYCLES = UV_FILTER_NS / CLK_PERIOD_NS;
    localparam int OC_CYCLE_LIMIT = 8;

    // thresholds in millivolts
    localparam logic [12:0] OV_FIXED_MV = 13'h0834;
    localparam logic [12:0] OV_HYST_MV = 13'h0019;

    // reference ramp-down: 0.5 mV/us is one millivolt every 2000 ns
    localparam int RAMP_NS_PER_MV = 2000;
    localparam int RAMP_STEP_CYCLES = RAMP_NS_PER_MV / CLK_PERIOD_NS;

    // telemetry
    localparam logic [7:0] CMD_OUTPUT_CURRENT = 8'h8C;
    localparam logic [7:0] CMD_CURRENT_LIMIT = 8'hDD;
    localparam logic [15:0] TELEMETRY_MAX = 16'h00FF;
    localparam logic [15:0] TELEMETRY_RESET = 16'h0000;

    // strap bits
    localparam int STRAP_OV_LATCH_BIT = 0;
    localparam int STRAP_UVOC_LATCH_BIT = 1;

    typedef enum logic [3:0] {
        ST_OFF = 4'h0,
        ST_SOFT_START = 4'h1,
        ST_PG_DELAY = 4'h2,
        ST_RUN = 4'h3,
        ST_OV_RECOVER = 4'h4,
        ST_OV_RAMP = 4'h5,
        ST_OV_HOLD = 4'h6,
        ST_HICCUP = 4'h7,
        ST_LATCHED = 4'h8
    } rfs_state_type;

endpackage

// [logic/rfs_supervisor.sv]
// Operation
// R01 - capture current limit once at enable
// R02 - limit code one amp per bit, saturating 255
// R03 - output current readable at 0x8C, max 00FFh
// R04 - above 255 A, code 255 means max load; a full-scale monitor code reads 254 instead
// R05 - mode strap picks recoverable or latching overvoltage
// R06 - overvoltage over 1us: power-good low, low-sides on
// R07 - recoverable overvoltage clears 25 mV below threshold
// R08 - recoverable soft-start uses fixed 2.1 V threshold
// R09 - latching overvoltage ramps reference down at 0.5mV/us
// R10 - low-sides toggle tracking ramp with 25 mV hysteresis
// R11 - reference at zero: low-sides held on
// R12 - latching soft-start threshold fixed 2.1 V until ramp
// R13 - latched overvoltage waits for supply or enable toggle
// R14 - overvoltage armed from soft-start, off when idle
// R15 - undervoltage over 5us: power-good low, outputs mid
// R16 - undervoltage goes hiccup or latch per strap
// R17 - undervoltage armed after power-good delay only
// R18 - per-phase cycle-by-cycle on-time truncation
// R19 - all phases limited over 8 cycles: fault
// R20 - overcurrent latch waits for toggle, hiccup retries
// R21 - overcurrent armed from soft-start, off when idle
// R22 - mid level releases both pull-up and pull-down
// R23 - hiccup interval is a clocked design parameter
`timescale 1ns/1ns
module rfs_supervisor #(
    parameter int PHASES = 6,
    parameter int HICCUP_CYCLES = 20000,
    parameter int PG_DELAY_CYCLES = 20000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // system control
    input wire logic enable,
    input wire logic five_volt_supply_good,
    input wire logic [1:0] fault_mode_strap,
    // soft-start handshake
    output logic soft_start_run,
    input wire logic soft_start_done,
    // voltage codes in millivolts
    input wire logic [11:0] sense_mv,
    input wire logic [11:0] target_ref_mv,
    input wire logic [11:0] overvoltage_offset,
    input wire logic [11:0] undervoltage_offset,
    output logic [11:0] reference_mv,
    // current sense
    input wire logic [9:0] current_limit_pin,
    input wire logic [9:0] current_monitor_pin,
    input wire logic [PHASES-1:0] phase_active,
    input wire logic [PHASES-1:0] phase_over_limit,
    input wire logic [PHASES-1:0] pwm_demand,
    input wire logic switch_cycle_tick,
    // switching outputs, oe low gives mid level
    output logic [PHASES-1:0] pwm_out,
    output logic [PHASES-1:0] pwm_oe,
    // status
    output logic power_good_output,
    // telemetry command port
    input wire logic read_strobe,
    input wire logic [7:0] read_cmd,
    output logic [15:0] read_data,
    output logic read_valid,
    output logic read_unsupported
);

    initial begin
        if (PHASES < 1 || PHASES > 12) begin
            $error("rfs_supervisor: PHASES out of range");
        end
        if (HICCUP_CYCLES < 1 || HICCUP_CYCLES >= (1 << 24)) begin
            $error("rfs_supervisor: HICCUP_CYCLES out of range");
        end
        if (PG_DELAY_CYCLES < 1 || PG_DELAY_CYCLES >= (1 << 24)) begin
            $error("rfs_supervisor: PG_DELAY_CYCLES out of range");
        end
    end

    rfs_pkg::rfs_state_type state;
    rfs_pkg::rfs_state_type next_state;

    logic ov_latch_mode;
    logic uvoc_latch_mode;
    logic ov_tripped_once;
    logic [23:0] wait_count;
    logic [7:0] ov_count;
    logic [7:0] uv_count;
    logic [3:0] oc_count;
    logic [5:0] ramp_div;
    logic [11:0] ramp_mv;
    logic ramp_low_on;
    logic [7:0] current_limit_reading;
    logic [7:0] output_current_reading;

    logic run_ok;
    logic ov_armed;
    logic uv_armed;
    logic oc_armed;
    logic [12:0] ref_ext;
    logic [12:0] ov_thresh;
    logic [12:0] ov_release;
    logic [12:0] uv_thresh;
    logic ov_above;
    logic ov_below_release;
    logic uv_below;
    logic ov_trip;
    logic uv_trip;
    logic oc_trip;
    logic all_limited;
    logic [17:0] iout_product;

    assign run_ok = enable && five_volt_supply_good;

    // ramp reference replaces the external one once ramping has begun
    assign reference_mv = (state == rfs_pkg::ST_OV_RAMP ||
                           state == rfs_pkg::ST_OV_HOLD) ?
                          ramp_mv : target_ref_mv; // R09
    assign ref_ext = {1'b0, reference_mv};

    // fixed threshold during start-up, relative after a trip
    always_comb begin
        ov_thresh = ref_ext + {1'b0, overvoltage_offset};
        if ((state == rfs_pkg::ST_SOFT_START ||
             state == rfs_pkg::ST_PG_DELAY) &&
            !(ov_tripped_once && !ov_latch_mode)) begin
            ov_thresh = rfs_pkg::OV_FIXED_MV; // R08 R12
        end
    end

    assign ov_release = (ov_thresh > rfs_pkg::OV_HYST_MV) ?
                        ov_thresh - rfs_pkg::OV_HYST_MV : 13'h0000;
    assign uv_thresh = (ref_ext > {1'b0, undervoltage_offset}) ?
                       ref_ext - {1'b0, undervoltage_offset} : 13'h0000;
    assign ov_above = {1'b0, sense_mv} > ov_thresh;
    assign ov_below_release = {1'b0, sense_mv} < ov_release; // R07 R10
    assign uv_below = {1'b0, sense_mv} < uv_thresh;

    // detector windows
    assign ov_armed = state == rfs_pkg::ST_SOFT_START ||
                      state == rfs_pkg::ST_PG_DELAY ||
                      state == rfs_pkg::ST_RUN; // R14
    assign uv_armed = state == rfs_pkg::ST_RUN; // R17
    assign oc_armed = ov_armed; // R21

    // "longer than" means strictly past the filter time
    assign ov_trip = ov_armed && ov_above &&
                     ov_count == 8'(rfs_pkg::OV_FILTER_CYCLES); // R06
    assign uv_trip = uv_armed && uv_below &&
                     uv_count == 8'(rfs_pkg::UV_FILTER_CYCLES); // R15
    assign all_limited = |phase_active &&
                         ((phase_over_limit & phase_active) ==
                          phase_active);
    assign oc_trip = oc_armed && switch_cycle_tick && all_limited &&
                     oc_count == 4'(rfs_pkg::OC_CYCLE_LIMIT); // R19

    always_ff @(posedge clk) begin
        if (rst || !ov_armed || !ov_above) begin
            ov_count <= 8'h00;
        end else if (ov_count != 8'(rfs_pkg::OV_FILTER_CYCLES)) begin
            ov_count <= ov_count + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !uv_armed || !uv_below) begin
            uv_count <= 8'h00;
        end else if (uv_count != 8'(rfs_pkg::UV_FILTER_CYCLES)) begin
            uv_count <= uv_count + 8'h01;
        end
    end

    // counts consecutive switching cycles with every active phase limited
    always_ff @(posedge clk) begin
        if (rst || !oc_armed) begin
            oc_count <= 4'h0;
        end else if (switch_cycle_tick) begin
            if (!all_limited) begin
                oc_count <= 4'h0;
            end else if (oc_count != 4'(rfs_pkg::OC_CYCLE_LIMIT)) begin
                oc_count <= oc_count + 4'h1; // R19
            end
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            rfs_pkg::ST_OFF: begin
                if (run_ok) begin
                    next_state = rfs_pkg::ST_SOFT_START;
                end
            end
            rfs_pkg::ST_SOFT_START: begin
                if (soft_start_done) begin
                    next_state = rfs_pkg::ST_PG_DELAY;
                end
            end
            rfs_pkg::ST_PG_DELAY: begin
                if (wait_count == 24'(PG_DELAY_CYCLES - 1)) begin
                    next_state = rfs_pkg::ST_RUN;
                end
            end
            rfs_pkg::ST_OV_RECOVER: begin
                if (ov_below_release) begin
                    next_state = rfs_pkg::ST_RUN; // R07
                end
            end
            rfs_pkg::ST_OV_RAMP: begin
                if (ramp_mv == 12'h000) begin
                    next_state = rfs_pkg::ST_OV_HOLD; // R11
                end
            end
            rfs_pkg::ST_HICCUP: begin
                if (wait_count == 24'(HICCUP_CYCLES - 1)) begin
                    next_state = rfs_pkg::ST_SOFT_START; // R16 R20 R23
                end
            end
            default: begin
            end
        endcase
        if (ov_trip) begin
            next_state = ov_latch_mode ? rfs_pkg::ST_OV_RAMP :
                         rfs_pkg::ST_OV_RECOVER; // R05
        end else if (uv_trip || oc_trip) begin
            next_state = uvoc_latch_mode ? rfs_pkg::ST_LATCHED :
                         rfs_pkg::ST_HICCUP; // R16 R20
        end
        // latched states leave only through a supply or enable drop
        if (!run_ok) begin
            next_state = rfs_pkg::ST_OFF; // R13 R20
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= rfs_pkg::ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // shared wait counter for power-good delay and hiccup idle
    always_ff @(posedge clk) begin
        if (rst || next_state != state) begin
            wait_count <= 24'h000000;
        end else if (state == rfs_pkg::ST_PG_DELAY ||
                     state == rfs_pkg::ST_HICCUP) begin
            wait_count <= wait_count + 24'h000001; // R23
        end
    end

    // strap is sampled when leaving off, not on hiccup restarts, so a toggle can change the mode
    always_ff @(posedge clk) begin
        if (rst) begin
            ov_latch_mode <= 1'b0;
            uvoc_latch_mode <= 1'b0;
        end else if (state == rfs_pkg::ST_OFF && run_ok) begin
            ov_latch_mode <=
                fault_mode_strap[rfs_pkg::STRAP_OV_LATCH_BIT]; // R05
            uvoc_latch_mode <=
                fault_mode_strap[rfs_pkg::STRAP_UVOC_LATCH_BIT]; // R16
        end
    end

    always_ff @(posedge clk) begin
        if (rst || state == rfs_pkg::ST_OFF) begin
            ov_tripped_once <= 1'b0;
        end else if (ov_trip) begin
            ov_tripped_once <= 1'b1; // R08
        end
    end

    // reference ramp-down, one millivolt per step interval
    always_ff @(posedge clk) begin
        if (rst) begin
            ramp_mv <= 12'h000;
            ramp_div <= 6'h00;
        end else if (ov_trip && ov_latch_mode) begin
            ramp_mv <= target_ref_mv;
            ramp_div <= 6'h00;
        end else if (state == rfs_pkg::ST_OV_RAMP && ramp_mv != 12'h000) begin
            if (ramp_div == 6'(rfs_pkg::RAMP_STEP_CYCLES - 1)) begin
                ramp_div <= 6'h00;
                ramp_mv <= ramp_mv - 12'h001; // R09
            end else begin
                ramp_div <= ramp_div + 6'h01;
            end
        end
    end

    // low-sides on above threshold, released below it less hysteresis
    always_ff @(posedge clk) begin
        if (rst || state != rfs_pkg::ST_OV_RAMP) begin
            ramp_low_on <= 1'b1;
        end else if (ov_above) begin
            ramp_low_on <= 1'b1; // R10
        end else if (ov_below_release) begin
            ramp_low_on <= 1'b0; // R10
        end
    end

    // switching outputs; oe low is the mid level with both drivers off
    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_out <= '0;
            pwm_oe <= '0;
        end else begin
            case (next_state)
                rfs_pkg::ST_SOFT_START, rfs_pkg::ST_PG_DELAY,
                rfs_pkg::ST_RUN: begin
                    pwm_out <= pwm_demand & ~phase_over_limit; // R18
                    pwm_oe <= phase_active;
                end
                rfs_pkg::ST_OV_RECOVER, rfs_pkg::ST_OV_HOLD: begin
                    pwm_out <= '0; // R06 R11
                    pwm_oe <= '1;
                end
                rfs_pkg::ST_OV_RAMP: begin
                    pwm_out <= '0;
                    pwm_oe <= {PHASES{ramp_low_on}}; // R09 R10
                end
                default: begin
                    pwm_out <= '0;
                    pwm_oe <= '0; // R15 R19 R22
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            power_good_output <= 1'b0;
        end else begin
            power_good_output <= next_state == rfs_pkg::ST_RUN; // R06 R15
        end
    end

    assign soft_start_run = state == rfs_pkg::ST_SOFT_START;

    // current-limit code captured on the start-up edge only
    always_ff @(posedge clk) begin
        if (rst) begin
            current_limit_reading <= 8'h00;
        end else if (state == rfs_pkg::ST_OFF && run_ok) begin
            if (current_limit_pin > 10'(rfs_pkg::TELEMETRY_MAX)) begin
                current_limit_reading <= 8'hFF; // R02
            end else begin
                current_limit_reading <= current_limit_pin[7:0]; // R01
            end
        end
    end

    // monitor code is a fraction of full scale; full scale is the limit
    assign iout_product = current_monitor_pin * current_limit_reading;

    always_ff @(posedge clk) begin
        if (rst) begin
            output_current_reading <= 8'h00;
        end else begin
            output_current_reading <= iout_product[17:10]; // R03 R04
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            read_data <= rfs_pkg::TELEMETRY_RESET;
            read_valid <= 1'b0;
            read_unsupported <= 1'b0;
        end else begin
            read_valid <= read_strobe;
            read_unsupported <= 1'b0;
            if (!read_strobe) begin
                read_data <= read_data;
            end else if (read_cmd == rfs_pkg::CMD_OUTPUT_CURRENT) begin
                read_data <= {8'h00, output_current_reading}; // R03
            end else if (read_cmd == rfs_pkg::CMD_CURRENT_LIMIT) begin
                read_data <= {8'h00, current_limit_reading}; // R01
            end else begin
                read_data <= rfs_pkg::TELEMETRY_RESET;
                read_unsupported <= 1'b1;
            end
        end
    end

endmodule // rfs_supervisor

// [tb/rfs_properties.sv]
`timescale 1ns/1ns
module rfs_properties #(
    parameter int PHASES = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control and sense
    input wire logic enable,
    input wire logic five_volt_supply_good,
    input wire logic soft_start_run,
    input wire logic [11:0] sense_mv,
    input wire logic [11:0] overvoltage_offset,
    input wire logic [11:0] undervoltage_offset,
    input wire logic [11:0] reference_mv,
    // outputs
    input wire logic [PHASES-1:0] pwm_oe,
    input wire logic power_good_output,
    // telemetry
    input wire logic read_strobe,
    input wire logic [7:0] read_cmd,
    input wire logic [15:0] read_data,
    input wire logic read_valid,
    input wire logic read_unsupported
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] ov_cnt;
    logic [7:0] uv_cnt;
    logic [12:0] ov_level;
    logic [12:0] uv_level;
    logic known_cmd;
    assign ov_level = {1'b0, reference_mv} + {1'b0, overvoltage_offset};
    assign uv_level = {1'b0, sense_mv} + {1'b0, undervoltage_offset};
    assign known_cmd = read_cmd == rfs_pkg::CMD_OUTPUT_CURRENT
        || read_cmd == rfs_pkg::CMD_CURRENT_LIMIT;
    // run length of an excursion seen while power is good
    always_ff @(posedge clk) begin
        if (rst || !power_good_output || {1'b0, sense_mv} <= ov_level) begin
            ov_cnt <= 8'h00;
        end else begin
            ov_cnt <= ov_cnt + 8'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (rst || !power_good_output ||
            uv_level >= {1'b0, reference_mv}) begin
            uv_cnt <= 8'h00;
        end else begin
            uv_cnt <= uv_cnt + 8'h01;
        end
    end
    sequence shut_down;
        !enable || !five_volt_supply_good;
    endsequence
    sequence leave_soft_start;
        $fell(soft_start_run) ##0 enable;
    endsequence
    read_answer_a: assert property (
        read_strobe && known_cmd |=> read_valid && read_data[15:8] == 8'h00)
        else $error("read answer missing");
    unknown_read_a: assert property (
        read_strobe && !known_cmd |=> read_unsupported
        && read_data == rfs_pkg::TELEMETRY_RESET)
        else $error("unknown read not refused");
    read_range_a: assert property (
        read_valid |-> read_data <= rfs_pkg::TELEMETRY_MAX)
        else $error("reading above full scale");
    shut_down_a: assert property (
        shut_down |=> pwm_oe == '0 && !power_good_output)
        else $error("outputs active while shut down");
    start_good_a: assert property (
        soft_start_run |-> !power_good_output)
        else $error("power good during soft start");
    good_delay_a: assert property (
        leave_soft_start |-> !power_good_output[*8])
        else $error("power good before its delay");
    ov_filter_a: assert property (
        ov_cnt < 8'h18)
        else $error("overvoltage not tripped");
    uv_filter_a: assert property (
        uv_cnt < 8'h68)
        else $error("undervoltage not tripped");
endmodule // rfs_properties

bind rfs_supervisor rfs_properties #(.PHASES(PHASES)) rfs_properties_u (
    .clk(clk), .rst(rst), .enable(enable),
    .five_volt_supply_good(five_volt_supply_good),
    .soft_start_run(soft_start_run), .sense_mv(sense_mv),
    .overvoltage_offset(overvoltage_offset),
    .undervoltage_offset(undervoltage_offset),
    .reference_mv(reference_mv), .pwm_oe(pwm_oe),
    .power_good_output(power_good_output), .read_strobe(read_strobe),
    .read_cmd(read_cmd), .read_data(read_data), .read_valid(read_valid),
    .read_unsupported(read_unsupported)
);

// [tb/rfs_power_stage.sv]
`timescale 1ns/1ns
module rfs_power_stage #(
    parameter int PHASES = 6,
    parameter int TICK_CYCLES = 16
) (
    // clock
    input wire logic clk,
    // commands from the supervisor
    input wire logic [PHASES-1:0] pwm_out,
    input wire logic [PHASES-1:0] pwm_oe,
    // load set by the bench
    input wire logic [PHASES-1:0] overload,
    // sense back to the supervisor
    output logic [PHASES-1:0] phase_over_limit,
    output logic switch_cycle_tick,
    // pin level per phase: 0 low, 1 high, 2 mid
    output logic [2*PHASES-1:0] stage_level
);
    // free-running switching period, so the model needs no reset pin
    logic [7:0] tick_cnt = 8'h00;
    always @(posedge clk) begin
        tick_cnt <= (tick_cnt == 8'(TICK_CYCLES - 1)) ? 8'h00 :
                    tick_cnt + 8'h01;
        switch_cycle_tick <= tick_cnt == 8'h00;
    end
    // a floating phase carries no current, so no limit report
    assign phase_over_limit = overload & pwm_oe;
    for (genvar i = 0; i < PHASES; i++) begin : g_lvl
        assign stage_level[2*i+:2] =
            pwm_oe[i] ? {1'b0, pwm_out[i]} : 2'h2;
    end
endmodule // rfs_power_stage

// [tb/test_regulator_fault_supervisor.sv]
`timescale 1ns/1ns
module test_regulator_fault_supervisor;
    localparam int PH = 2;
    // starts low before time zero, so no false falling edge at start
    logic clk = 1'b0;
    logic rst, enable, supply, ss_done, ss_run, strobe;
    logic tick, pg, rd_valid, rd_unsup;
    logic [1:0] strap;
    logic [11:0] sense, target, ov_off, uv_off, ref_mv;
    logic [9:0] lim, mon;
    logic [PH-1:0] active, demand, overload, over_limit, pwm_out, pwm_oe;
    logic [7:0] cmd;
    logic [15:0] rd_data;
    logic [2*PH-1:0] level;
    int n_mismatch = 0;
    int total_checks = 0;

    rfs_supervisor #(.PHASES(PH), .HICCUP_CYCLES(10), .PG_DELAY_CYCLES(10))
    dut_u (
        .clk(clk), .rst(rst), .enable(enable),
        .five_volt_supply_good(supply), .fault_mode_strap(strap),
        .soft_start_run(ss_run), .soft_start_done(ss_done),
        .sense_mv(sense), .target_ref_mv(target),
        .overvoltage_offset(ov_off), .undervoltage_offset(uv_off),
        .reference_mv(ref_mv), .current_limit_pin(lim),
        .current_monitor_pin(mon), .phase_active(active),
        .phase_over_limit(over_limit), .pwm_demand(demand),
        .switch_cycle_tick(tick), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
        .power_good_output(pg), .read_strobe(strobe), .read_cmd(cmd),
        .read_data(rd_data), .read_valid(rd_valid),
        .read_unsupported(rd_unsup)
    );
    rfs_power_stage #(.PHASES(PH), .TICK_CYCLES(16)) stage_u (
        .clk(clk), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .overload(overload),
        .phase_over_limit(over_limit), .switch_cycle_tick(tick),
        .stage_level(level)
    );

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen,
            input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // bounded wait, so a stuck state machine ends the test cleanly
    task automatic wait_on(ref logic sig, input logic lvl, input string name);
        int i;
        i = 0;
        while (sig !== lvl && i < 2000) begin
            cyc(1);
            i++;
        end
        check(name, sig, lvl);
    endtask

    task automatic read(input logic [7:0] c, input logic [15:0] exp);
        strobe = 1'b1;
        cmd = c;
        cyc(1);
        strobe = 1'b0;
        check("read data", rd_data, exp);
        if (c == rfs_pkg::CMD_OUTPUT_CURRENT ||
            c == rfs_pkg::CMD_CURRENT_LIMIT) begin
            check("read valid", rd_valid, 1'b1);
        end else begin
            check("read refused", rd_unsup, 1'b1);
        end
        // one idle edge, so the next call never re-raises strobe at once
        cyc(1);
    endtask

    task automatic power_up;
        enable = 1'b1;
        wait_on(ss_run, 1'b1, "soft start");
        ss_done = 1'b1;
        cyc(1);
        ss_done = 1'b0;
        wait_on(pg, 1'b1, "power good");
    endtask

    task automatic restart;
        enable = 1'b0;
        cyc(2);
        check("levels", level, 4'hA);
        power_up();
    endtask

    task automatic t_telemetry;
        power_up();
        lim = 10'h032;
        read(rfs_pkg::CMD_CURRENT_LIMIT, 16'h0064);
        read(rfs_pkg::CMD_OUTPUT_CURRENT, 16'h0032);
        read(8'h00, rfs_pkg::TELEMETRY_RESET);
        lim = 10'h12C;
        mon = 10'h3FF;
        restart();
        read(rfs_pkg::CMD_CURRENT_LIMIT, rfs_pkg::TELEMETRY_MAX);
        read(rfs_pkg::CMD_OUTPUT_CURRENT, 16'h00FE);
    endtask

    task automatic t_ov_recover;
        sense = 12'h44D;
        cyc(15);
        check("power good", pg, 1'b1);
        cyc(10);
        check("power good", pg, 1'b0);
        check("levels", level, 4'h0);
        sense = 12'h438;
        cyc(5);
        check("power good", pg, 1'b0);
        sense = 12'h42E;
        wait_on(pg, 1'b1, "power good");
        sense = 12'h3E8;
    endtask

    task automatic t_uv_hiccup;
        sense = 12'h320;
        cyc(90);
        check("power good", pg, 1'b1);
        cyc(15);
        check("power good", pg, 1'b0);
        check("levels", level, 4'hA);
        sense = 12'h3E8;
        power_up();
    endtask

    task automatic t_oc_latch;
        strap = 2'h2;
        restart();
        overload = 2'h1;
        cyc(3);
        check("switching", pwm_out, 2'h2);
        overload = 2'h3;
        cyc(100);
        check("power good", pg, 1'b1);
        cyc(100);
        check("levels", level, 4'hA);
        overload = 2'h0;
        cyc(40);
        check("soft start", ss_run, 1'b0);
        restart();
    endtask

    task automatic t_ov_latch;
        strap = 2'h1;
        target = 12'h014;
        uv_off = 12'h00A;
        sense = 12'h014;
        restart();
        sense = 12'h7D0;
        cyc(25);
        check("power good", pg, 1'b0);
        check("levels", level, 4'h0);
        cyc(400);
        check("ramp", ref_mv >= 12'h009 && ref_mv <= 12'h00B, 1'b1);
        // output falls below the ramp level plus offset less hysteresis, then rises
        sense = 12'h032;
        cyc(3);
        check("levels", level, 4'hA);
        sense = 12'h7D0;
        cyc(3);
        check("levels", level, 4'h0);
        cyc(440);
        check("ramp", ref_mv, 12'h000);
        check("levels", level, 4'h0);
        supply = 1'b0;
        cyc(2);
        check("levels", level, 4'hA);
        supply = 1'b1;
        // 2.0 V is above the relative level but below the start level
        power_up();
        sense = 12'h014;
        cyc(5);
        check("power good", pg, 1'b1);
    endtask

    initial begin
        rst = 1'b1;
        enable = 1'b0;
        supply = 1'b1;
        strap = 2'h0;
        ss_done = 1'b0;
        sense = 12'h3E8;
        target = 12'h3E8;
        ov_off = 12'h064;
        uv_off = 12'h064;
        lim = 10'h064;
        mon = 10'h200;
        active = 2'h3;
        demand = 2'h3;
        overload = 2'h0;
        strobe = 1'b0;
        cmd = 8'h00;
        cyc(10);
        rst = 1'b0;
        t_telemetry();
        t_ov_recover();
        t_uv_hiccup();
        t_oc_latch();
        t_ov_latch();
        results();
    end

    initial begin
        #(5000 * 50);
        n_mismatch++;
        results();
    end
endmodule // test_regulator_fault_supervisor
